//--- rtl/wma_filter.sv
// windowed moving average filter with per-function settings
// assumes converter samples and host commands arrive on ref_clk_i
//
// Overview of operation
// - readings kept in a fifo stack
// - each conversion yields one new average
// - first conversion fills every stack location
// - valid output right after first conversion
// - depth programmable per function, 2 to 100
// - out-of-window conversion restarts the filter
// - out-of-window conversion fills whole stack at once
// - output is average, or single out-of-window value
// - threshold is percent times range full scale
// - local path offers five fixed window choices
// - remote window accepted from 0.01 to 100
// - 100 percent window disables threshold check
// - concurrent function filters current, passes voltage
// - filter bypassed in battery functions
// - settings held per function, current one applied
// - only moving average type accepted
// - digits per function 4.5/5.5/6.5, default 6.5
// - digits coded as 4, 5 or 6
// - digits affect display formatting only
// - battery functions lock digits at maximum
// - new digits apply from next measurement
// - autozero is one global switch
`timescale 1ns/1ps

module wma_filter (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] func_i,
  input wire logic batt_i,
  input wire logic az_en_i,
  input wire logic [23:0] range_fs_i,
  input wire logic clr_i,
  input wire wma_pkg::wma_cmd_t cmd_i,
  input wire wma_pkg::wma_samp_t samp_i,
  output wma_pkg::wma_res_t res_o,
  output logic cmd_err_o,
  output logic az_active_o,
  output logic filt_active_o
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    wma_pkg::wma_st_t st;
    logic [6:0] ptr;
    logic signed [31:0] sum;
    logic signed [23:0] avg;
    logic [1:0] fn;
    wma_pkg::wma_fn_cfg_t [2:0] cfg;
    wma_pkg::wma_res_t res;
    logic err;
    logic az;
  } wma_state_t;

  wma_state_t s;
  wma_state_t next_s;
  logic signed [23:0] mem [0:wma_pkg::MEM_N-1];
  logic [1:0] fsel;
  wma_pkg::wma_fn_cfg_t cur;
  logic signed [24:0] diff;
  logic [24:0] adiff;
  logic [37:0] thr;
  logic outside;
  logic bypass;
  logic start;
  logic mem_fill;
  logic mem_wr;
  logic signed [31:0] dsig;

  // unknown function code falls back to concurrent rather than indexing out
  assign fsel = func_i[1] ? wma_pkg::FN_CONC : func_i;
  assign cur = s.cfg[fsel];
  assign dsig = $signed({25'h0, cur.depth});

  // ****************************************************
  // window test
  // ****************************************************
  always_comb begin
    diff = 25'(samp_i.data) - 25'(s.avg);
    adiff = diff[24] ? 25'(-diff) : 25'(diff);
    // multiply before divide keeps 0.01 percent resolution
    thr = (38'(range_fs_i) * 38'(cur.win)) / wma_pkg::WIN_SCALE;
    outside = (cur.win != wma_pkg::WIN_FULL)
      && ({13'h0, adiff} > thr);
    bypass = batt_i | ~cur.en
      | (fsel == wma_pkg::FN_CONC && samp_i.volt);
    start = (s.st == wma_pkg::ST_EMPTY) | (s.fn != fsel) | clr_i;
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    next_s = s;
    next_s.res.valid = 1'b0;
    next_s.err = 1'b0;
    next_s.fn = fsel;
    next_s.az = az_en_i & ~batt_i;
    mem_fill = 1'b0;
    mem_wr = 1'b0;
    if (start) begin
      next_s.st = wma_pkg::ST_EMPTY;
    end
    if (samp_i.valid) begin
      next_s.res.valid = 1'b1;
      // digits are latched per reading so a change shows from the next
      next_s.res.digits = batt_i ? wma_pkg::DIG_MAX : cur.digits;
      if (bypass) begin
        next_s.res.data = samp_i.data;
        next_s.res.filt = 1'b0;
      end else if (start || outside) begin
        mem_fill = 1'b1;
        next_s.sum = 32'(samp_i.data) * dsig;
        next_s.ptr = 7'h00;
        next_s.avg = samp_i.data;
        next_s.res.data = samp_i.data;
        next_s.res.filt = 1'b1;
        next_s.st = wma_pkg::ST_RUN;
      end else begin
        mem_wr = 1'b1;
        next_s.sum = s.sum - 32'(mem[s.ptr]) + 32'(samp_i.data);
        next_s.avg = 24'(next_s.sum / dsig);
        next_s.res.data = next_s.avg;
        next_s.res.filt = 1'b1;
        next_s.ptr = (s.ptr == cur.depth - 7'h01) ? 7'h00 : s.ptr + 7'h01;
      end
    end
    if (cmd_i.wr) begin
      if (cmd_i.fn > wma_pkg::FN_CONC) begin
        next_s.err = 1'b1;
      end else begin
        case (cmd_i.field)
          wma_pkg::FLD_EN: begin
            next_s.cfg[cmd_i.fn].en = cmd_i.data[0];
          end
          wma_pkg::FLD_DEPTH: begin
            if (cmd_i.data >= 16'(wma_pkg::DEPTH_MIN) &&
                cmd_i.data <= 16'(wma_pkg::DEPTH_MAX)) begin
              next_s.cfg[cmd_i.fn].depth = cmd_i.data[6:0];
            end else begin
              next_s.err = 1'b1;
            end
          end
          wma_pkg::FLD_WIN: begin
            if (cmd_i.data >= 16'(wma_pkg::WIN_MIN) &&
                cmd_i.data <= 16'(wma_pkg::WIN_FULL)) begin
              next_s.cfg[cmd_i.fn].win = cmd_i.data[13:0];
            end else begin
              next_s.err = 1'b1;
            end
          end
          wma_pkg::FLD_WIN_LOCAL: begin
            case (cmd_i.data)
              16'h0000: next_s.cfg[cmd_i.fn].win = wma_pkg::WIN_L0;
              16'h0001: next_s.cfg[cmd_i.fn].win = wma_pkg::WIN_L1;
              16'h0002: next_s.cfg[cmd_i.fn].win = wma_pkg::WIN_L2;
              16'h0003: next_s.cfg[cmd_i.fn].win = wma_pkg::WIN_L3;
              16'h0004: next_s.cfg[cmd_i.fn].win = wma_pkg::WIN_L4;
              default: next_s.err = 1'b1;
            endcase
          end
          wma_pkg::FLD_DIGITS: begin
            // digits feed only res_o.digits, never the reading itself
            if (!batt_i && cmd_i.data >= 16'(wma_pkg::DIG_MIN) &&
                cmd_i.data <= 16'(wma_pkg::DIG_MAX)) begin
              next_s.cfg[cmd_i.fn].digits = cmd_i.data[2:0];
            end else begin
              next_s.err = 1'b1;
            end
          end
          wma_pkg::FLD_TYPE: begin
            next_s.err = (cmd_i.data != wma_pkg::TYPE_MOVING);
          end
          default: begin
            next_s.err = 1'b1;
          end
        endcase
      end
      // a stack built at the old depth would average wrong entries
      if (cmd_i.fn == fsel && (next_s.cfg[fsel].en != s.cfg[fsel].en ||
          next_s.cfg[fsel].depth != s.cfg[fsel].depth)) begin
        next_s.st = wma_pkg::ST_EMPTY;
      end
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s.st <= wma_pkg::ST_EMPTY;
      s.ptr <= 7'h00;
      s.sum <= 32'h0000_0000;
      s.avg <= 24'h00_0000;
      s.fn <= 2'h0;
      for (int i = 0; i < 3; i++) begin
        s.cfg[i].en <= 1'b0;
        s.cfg[i].depth <= wma_pkg::DEPTH_RST;
        s.cfg[i].win <= wma_pkg::WIN_RST;
        s.cfg[i].digits <= wma_pkg::DIG_RST;
      end
      s.res <= '0;
      s.err <= 1'b0;
      s.az <= wma_pkg::AZ_RST;
    end else begin
      s <= next_s;
    end
  end

  // stack storage has no reset; it is always filled before it is read
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < wma_pkg::MEM_N; i++) begin
      if (mem_fill) begin
        mem[i] <= samp_i.data;
      end
    end
    if (mem_wr) begin
      mem[s.ptr] <= samp_i.data;
    end
  end

  assign res_o = s.res;
  assign cmd_err_o = s.err;
  assign az_active_o = s.az;
  assign filt_active_o = cur.en & ~batt_i;

  // ****************************************************
  // assertions
  // ****************************************************
  property p_one_out;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    samp_i.valid |=> res_o.valid;
  endproperty
  a_one_out: assert property (p_one_out)
    else $error("no output after conversion");

  property p_first_fill;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    samp_i.valid && start && !bypass
      |=> res_o.filt && res_o.data == $past(samp_i.data);
  endproperty
  a_first_fill: assert property (p_first_fill)
    else $error("first conversion not output at once");

  property p_step;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    samp_i.valid && outside && !bypass
      |=> res_o.data == $past(samp_i.data) && s.ptr == 7'h00;
  endproperty
  a_step: assert property (p_step)
    else $error("step outside window not taken directly");

  property p_depth;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cur.depth >= wma_pkg::DEPTH_MIN && cur.depth <= wma_pkg::DEPTH_MAX;
  endproperty
  a_depth: assert property (p_depth)
    else $error("depth outside 2 to 100");

  // a full window must never refill: the pointer keeps walking
  property p_full_win;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    samp_i.valid && !bypass && !start && cur.win == wma_pkg::WIN_FULL
      && s.ptr != cur.depth - 7'h01
      |=> s.ptr != 7'h00;
  endproperty
  a_full_win: assert property (p_full_win)
    else $error("full window still rejects");

  property p_batt;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    samp_i.valid && batt_i
      |=> !res_o.filt && res_o.digits == wma_pkg::DIG_MAX;
  endproperty
  a_batt: assert property (p_batt)
    else $error("battery reading filtered or digits not max");

  property p_conc_volt;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    samp_i.valid && fsel == wma_pkg::FN_CONC && samp_i.volt
      |=> !res_o.filt && res_o.data == $past(samp_i.data);
  endproperty
  a_conc_volt: assert property (p_conc_volt)
    else $error("concurrent voltage was filtered");

  property p_depth_empty;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cmd_i.wr && cmd_i.field == wma_pkg::FLD_DEPTH && cmd_i.fn == fsel
      && cmd_i.data[6:0] != cur.depth && !cmd_err_o && !next_s.err
      |=> s.st == wma_pkg::ST_EMPTY;
  endproperty
  a_depth_empty: assert property (p_depth_empty)
    else $error("depth change kept stack");

  property p_win_range;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cur.win >= wma_pkg::WIN_MIN && cur.win <= wma_pkg::WIN_FULL;
  endproperty
  a_win_range: assert property (p_win_range)
    else $error("window outside 0.01 to 100 percent");

endmodule // wma_filter

//--- rtl/wma_pkg.sv
// constants, types and command codes of the windowed moving average filter
// assumes one system clock shared by converter, host command logic and filter
package wma_pkg;

  // ****************************************************
  // widths and limits
  // ****************************************************
  localparam int DW = 24;
  localparam int MEM_N = 100;
  localparam logic [6:0] DEPTH_MIN = 7'h02;
  localparam logic [6:0] DEPTH_MAX = 7'h64;
  localparam logic [6:0] DEPTH_RST = 7'h0A;
  // window held in hundredths of a percent of range
  localparam logic [13:0] WIN_MIN = 14'h0001;
  localparam logic [13:0] WIN_FULL = 14'h2710;
  localparam logic [13:0] WIN_RST = 14'h0001;
  localparam logic [37:0] WIN_SCALE = 38'h00_0000_2710;
  localparam logic [13:0] WIN_L0 = 14'h0001;
  localparam logic [13:0] WIN_L1 = 14'h000A;
  localparam logic [13:0] WIN_L2 = 14'h0064;
  localparam logic [13:0] WIN_L3 = 14'h03E8;
  localparam logic [13:0] WIN_L4 = 14'h2710;
  localparam logic [2:0] DIG_MIN = 3'h4;
  localparam logic [2:0] DIG_MAX = 3'h6;
  localparam logic [2:0] DIG_RST = 3'h6;
  localparam logic [15:0] TYPE_MOVING = 16'h0000;
  localparam logic AZ_RST = 1'h1;

  // ****************************************************
  // enumerations
  // ****************************************************
  typedef enum logic [1:0] {
    FN_VOLT = 2'h0,
    FN_CURR = 2'h1,
    FN_CONC = 2'h2
  } wma_fn_t;

  typedef enum logic [2:0] {
    FLD_EN = 3'h0,
    FLD_DEPTH = 3'h1,
    FLD_WIN = 3'h2,
    FLD_WIN_LOCAL = 3'h3,
    FLD_DIGITS = 3'h4,
    FLD_TYPE = 3'h5
  } wma_field_t;

  typedef enum logic [1:0] {
    ST_EMPTY = 2'h1,
    ST_RUN = 2'h2
  } wma_st_t;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic en;
    logic [6:0] depth;
    logic [13:0] win;
    logic [2:0] digits;
  } wma_fn_cfg_t;

  typedef struct packed {
    logic wr;
    logic [1:0] fn;
    logic [2:0] field;
    logic [15:0] data;
  } wma_cmd_t;

  typedef struct packed {
    logic valid;
    logic volt;
    logic signed [DW-1:0] data;
  } wma_samp_t;

  typedef struct packed {
    logic valid;
    logic filt;
    logic [2:0] digits;
    logic signed [DW-1:0] data;
  } wma_res_t;

endpackage

//--- verif/wma_conv_model.sv
// converter stand-in: one bench request becomes one sample strobe
// assumes requests change just after a rising edge of the shared clock
`timescale 1ns/1ps

module wma_conv_model (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic volt_i,
  input wire logic [23:0] data_i,
  output wma_pkg::wma_samp_t samp_o
);
  // ****************************************************
  // sample register
  // ****************************************************
  // idle lines show the inverse of the last value, so a stale copy
  // can never pass for a fresh reading
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp_o <= '0;
    end else begin
      samp_o.valid <= req_i;
      samp_o.volt <= req_i ? volt_i : ~samp_o.volt;
      samp_o.data <= req_i ? data_i : ~samp_o.data;
    end
  end
endmodule // wma_conv_model

//--- verif/tb.sv
// self-checking bench of the windowed moving average filter
// assumes the rtl package and the converter model are compiled first
`timescale 1ns/1ps

module tb;
  logic ref_clk_i, rst_n_i, batt_i, az_en_i, clr_i, req, volt;
  logic [1:0] func_i;
  logic [23:0] range_fs_i, dat;
  wma_pkg::wma_cmd_t cmd_i;
  wma_pkg::wma_samp_t samp_i;
  wma_pkg::wma_res_t res_o;
  logic cmd_err_o, az_active_o, filt_active_o;
  int error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'h2af5;
  logic [27:0] exp_q[$];
  logic en_m[3];
  logic [6:0] dep_m[3];
  logic [13:0] win_m[3];
  logic [2:0] dig_m[3];
  logic signed [23:0] hist[100];
  logic signed [23:0] avg_m;
  bit empty_m;
  logic [13:0] loc_w[5] = '{14'h0001, 14'h000A, 14'h0064, 14'h03E8, 14'h2710};
  // fn, field, data triples: refusals mixed with boundary accepts
  int t[] = '{3,0,1, 1,1,1, 1,1,101, 1,1,2, 1,1,100, 1,2,0, 1,2,10001,
    1,2,1, 1,3,5, 1,3,0, 1,3,1, 1,3,3, 1,3,2, 1,3,4, 1,4,3, 1,4,7,
    1,4,4, 1,4,5, 1,4,6, 1,5,1, 1,5,0, 1,6,0, 0,4,5};

  wma_conv_model conv_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .req_i(req), .volt_i(volt), .data_i(dat), .samp_o(samp_i));
  wma_filter dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .func_i(func_i), .batt_i(batt_i), .az_en_i(az_en_i),
    .range_fs_i(range_fs_i), .clr_i(clr_i), .cmd_i(cmd_i),
    .samp_i(samp_i), .res_o(res_o), .cmd_err_o(cmd_err_o),
    .az_active_o(az_active_o), .filt_active_o(filt_active_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************************
  // reporting
  // ****************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // results are matched to notes in order; also cuts a hang short
  always @(posedge ref_clk_i) begin
    #1;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
    if (res_o.valid === 1'b1)
      check({res_o.filt, res_o.digits, res_o.data},
        exp_q.size() ? exp_q.pop_front() : '1);
  end

  // ****************************************************
  // drivers with reference model
  // ****************************************************
  task automatic send(input logic signed [23:0] x, input logic v);
    longint s;
    logic f;
    int i;
    f = en_m[func_i] && !batt_i && !(func_i == 2'h2 && v);
    if (f) begin
      s = x - avg_m;
      if (s < 0) s = -s;
      if (empty_m ||
          s > longint'(range_fs_i) * win_m[func_i] / 10000) begin
        for (i = 0; i < 100; i++) hist[i] = x;
      end else begin
        for (i = 99; i > 0; i--) hist[i] = hist[i-1];
        hist[0] = x;
      end
      s = 0;
      for (i = 0; i < dep_m[func_i]; i++) s += hist[i];
      avg_m = 24'(s / int'(dep_m[func_i]));
      empty_m = 0;
    end
    exp_q.push_back({f, batt_i ? 3'h6 : dig_m[func_i],
      f ? avg_m : x});
    @(posedge ref_clk_i);
    req <= 1'b1;
    dat <= x;
    volt <= v;
  endtask

  task automatic cmd(input logic [1:0] f, input logic [2:0] fl,
                     input logic [15:0] v);
    logic bad;
    bad = f == 2'h3 || fl > 3'h5 || (fl == 3'h1 && (v < 2 || v > 100)) ||
      (fl == 3'h2 && (v < 1 || v > 10000)) || (fl == 3'h3 && v > 4) ||
      (fl == 3'h4 && (v < 4 || v > 6 || batt_i)) || (fl == 3'h5 && v != 0);
    if (!bad) begin
      if (fl < 3'h2 && f == func_i) empty_m = 1;
      case (fl)
        3'h0: en_m[f] = v[0];
        3'h1: dep_m[f] = v[6:0];
        3'h2: win_m[f] = v[13:0];
        3'h3: win_m[f] = loc_w[v[2:0]];
        3'h4: dig_m[f] = v[2:0];
        default: ;
      endcase
    end
    @(posedge ref_clk_i);
    req <= 1'b0;
    cmd_i <= {1'b1, f, fl, v};
    @(posedge ref_clk_i);
    cmd_i.wr <= 1'b0;
    #1 check({31'h0, cmd_err_o},
      {31'h0, bad});
  endtask

  // idle edge first, so an in-flight sample sees the old selection
  task automatic ctl(input logic [1:0] f, input logic b, c, a,
                     input logic [23:0] r);
    @(posedge ref_clk_i);
    req <= 1'b0;
    @(posedge ref_clk_i);
    if (c || f != func_i) empty_m = 1;
    func_i <= f;
    batt_i <= b;
    clr_i <= c;
    az_en_i <= a;
    range_fs_i <= r;
    @(posedge ref_clk_i);
    clr_i <= 1'b0;
    #1 check({31'h0, filt_active_o},
      {31'h0, en_m[f] & ~b});
    check({31'h0, az_active_o}, {31'h0, a & ~b});
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    rst_n_i = 1'b0;
    func_i = 2'h1;
    {batt_i, clr_i, req, volt} = 4'h0;
    az_en_i = 1'b1;
    dat = 24'h000000;
    range_fs_i = 24'h0F4240;
    cmd_i = '0;
    for (int i = 0; i < 3; i++) begin
      en_m[i] = 1'b0;
      dep_m[i] = 7'h0A;
      win_m[i] = 14'h0001;
      dig_m[i] = 3'h6;
    end
    empty_m = 1;
    avg_m = 24'h000000;
    repeat (2) @(posedge ref_clk_i);
    #1 check({res_o, cmd_err_o, az_active_o, filt_active_o},
      32'h00000002);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    send(24'sd1234, 1'b0);
    ctl(2'h1, 1'b0, 1'b0, 1'b1, 24'h0F4240);
    $display("test defaults done");
    for (int i = 0; i < t.size(); i += 3)
      cmd(2'(t[i]), 3'(t[i+1]), 16'(t[i+2]));
    $display("test commands done");
    cmd(2'h1, 3'h0, 16'h0001);
    cmd(2'h1, 3'h1, 16'h0004);
    for (int i = 1; i < 6; i++) send(24'(i * 100), 1'b0);
    send(-24'sd900000, 1'b0);
    cmd(2'h1, 3'h1, 16'h0002);
    for (int i = 1; i < 4; i++) send(24'(i * 77), 1'b0);
    cmd(2'h1, 3'h1, 16'h0064);
    for (int i = 1; i < 4; i++) send(24'(i * 1000), 1'b0);
    send(24'sd7, 1'b0);
    cmd(2'h1, 3'h4, 16'h0004);
    send(24'sd8, 1'b0);
    $display("test averaging done");
    cmd(2'h1, 3'h3, 16'h0002);
    cmd(2'h1, 3'h1, 16'h0004);
    ctl(2'h1, 1'b0, 1'b1, 1'b1, 24'h0F4240);
    send(24'sd0, 1'b0);
    send(24'sd10000, 1'b0);
    send(24'sd12501, 1'b0);
    ctl(2'h1, 1'b0, 1'b0, 1'b0, 24'h0186A0);
    send(24'sd12601, 1'b0);
    send(-24'sd5, 1'b0);
    cmd(2'h1, 3'h1, 16'h0007);
    for (int i = 0; i < 40; i++)
      send(24'($random(seed) % 20000), 1'($random(seed)));
    $display("test window done");
    cmd(2'h2, 3'h0, 16'h0001);
    cmd(2'h2, 3'h3, 16'h0003);
    ctl(2'h2, 1'b0, 1'b0, 1'b1, 24'h0F4240);
    for (int i = 0; i < 20; i++)
      send(24'($random(seed) % 200000), 1'($random(seed)));
    ctl(2'h0, 1'b0, 1'b0, 1'b1, 24'h0F4240);
    send(24'sd99, 1'b0);
    $display("test functions done");
    ctl(2'h2, 1'b1, 1'b0, 1'b1, 24'h0F4240);
    cmd(2'h2, 3'h4, 16'h0004);
    send(24'sd5, 1'b0);
    send(24'sd6, 1'b1);
    ctl(2'h2, 1'b0, 1'b1, 1'b0, 24'h0F4240);
    send(24'sd40, 1'b0);
    ctl(2'h2, 1'b0, 1'b0, 1'b0, 24'h0F4240);
    repeat (4) @(posedge ref_clk_i);
    check(32'(exp_q.size()), 32'h00000000);
    $display("test battery done");
    tally_and_finish();
  end
endmodule // tb
